// file: rtl/csc_regs.svh
// Command codes, field positions, reset values, strap codes and timing figures for current sharing.
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH

// Command codes on the command transaction port.
`define CSC_CMD_APP_CFG 8'hd1
`define CSC_CMD_LOAD_LINE 8'h60
`define CSC_CMD_STATUS 8'he1

// Reset values of the host-programmed words.
`define CSC_APP_CFG_RST 16'h0000
`define CSC_LOAD_LINE_RST 16'h0000

// Load-line code used while sharing is active.
`define CSC_LOAD_LINE_SHARE 16'hba80

// Field positions inside the application configuration word.
`define CSC_BLANK_HI 15
`define CSC_BLANK_LO 11
`define CSC_SENSE_HI 5
`define CSC_SENSE_LO 4
`define CSC_RAMP_BIT 2
`define CSC_SYNC_DRV_BIT 0
`define CSC_SENSE_RSVD 2'b11

// Strap resistance codes, in units of 100 ohm.
`define CSC_R_MEMBERS3 12'h0ed
`define CSC_R_POS0 12'h1a6
`define CSC_R_POS1 12'h1d0
`define CSC_R_POS2 12'h1ff
`define CSC_R_SS_LONG 12'h13c
`define CSC_R_SS_SHORT 12'h093

// Decoded strap values.
`define CSC_MEMBERS3 3'h3
`define CSC_MEMBERS_NONE 3'h0
`define CSC_POS0 3'h0
`define CSC_POS1 3'h1
`define CSC_POS2 3'h2
`define CSC_SS_DLY_LONG_MS 8'h0f
`define CSC_SS_DLY_SHORT_MS 8'h05
`define CSC_SS_RAMP_MS 8'h05

// Timing: blanking step per field count and the system clock period.
`define CSC_BLANK_STEP_NS 20
`define CSC_CLK_PERIOD_NS 10

`endif

// file: rtl/csc_pkg.sv
// Types shared by the current sharing configuration block.
package csc_pkg;

  typedef enum logic [1:0] {
    CSC_SENSE_GND_DOWN = 2'b00,
    CSC_SENSE_VOUT_DOWN = 2'b01,
    CSC_SENSE_VOUT_UP = 2'b10
  } csc_sense_t;

  typedef struct packed {
    logic share_en;
    logic [2:0] members;
    logic pos_ok;
    logic [2:0] position;
    logic ss_ok;
    logic [7:0] ss_delay_ms;
    logic [7:0] ss_ramp_ms;
  } csc_strap_t;

  typedef struct packed {
    logic [11:0] members;
    logic [11:0] position;
    logic [11:0] soft_start;
  } csc_strap_raw_t;

  typedef struct packed {
    logic straps_taken;
    csc_strap_t strap;
    logic [15:0] app_cfg;
    logic [15:0] load_line;
    logic dir_s1;
    logic dir_s2;
    logic phen_s1;
    logic phen_s2;
    logic phok_s1;
    logic phok_s2;
    logic [7:0] peer_s1;
    logic [7:0] peer_s2;
    logic [7:0] blank_cnt;
    logic meas_take;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
    logic phase_on;
    logic phase_bad;
    logic is_ref;
    logic sync_o;
    logic sync_oe;
    logic [15:0] cfg_eff;
    logic [15:0] load_line_eff;
  } csc_state_t;

endpackage

// file: rtl/csc_strap_decode.sv
// Decoder from measured strap resistances to current sharing settings.
`timescale 1ns/1ps
`include "csc_regs.svh"
module csc_strap_decode import csc_pkg::*; (
  input wire csc_strap_raw_t raw, // Measured strap resistances
  output csc_strap_t dec // Decoded settings
);

  always_comb begin
    dec = '0;
    if (raw.members == `CSC_R_MEMBERS3) begin // RULE_10
      dec.members = `CSC_MEMBERS3;
      dec.share_en = 1'b1;
    end else begin
      dec.members = `CSC_MEMBERS_NONE;
      dec.share_en = 1'b0;
    end
    dec.pos_ok = 1'b1;
    case (raw.position) // RULE_11
      `CSC_R_POS0: dec.position = `CSC_POS0;
      `CSC_R_POS1: dec.position = `CSC_POS1;
      `CSC_R_POS2: dec.position = `CSC_POS2;
      default: begin
        dec.position = `CSC_POS0;
        dec.pos_ok = 1'b0;
      end
    endcase
    dec.ss_ok = 1'b1;
    dec.ss_ramp_ms = `CSC_SS_RAMP_MS;
    case (raw.soft_start) // RULE_13
      `CSC_R_SS_LONG: dec.ss_delay_ms = `CSC_SS_DLY_LONG_MS;
      `CSC_R_SS_SHORT: dec.ss_delay_ms = `CSC_SS_DLY_SHORT_MS;
      default: begin
        dec.ss_delay_ms = `CSC_SS_DLY_SHORT_MS;
        dec.ss_ok = 1'b0;
      end
    endcase
  end

endmodule // csc_strap_decode

// file: rtl/csc_top.sv
// Current sharing configuration: command registers, strap capture, forced bits, blanking.
`timescale 1ns/1ps
`include "csc_regs.svh"

// Functional notes
// RULE_01: Blanking delay from config bits 15:11 suppresses measurements after switch edges.
// RULE_02: Host programs the same blanking delay into every controller of a group.
// RULE_03: Two-bit sense field picks ground-down, output-down or output-up sensing.
// RULE_04: Host selects the same sensing mode for all controllers of a group.
// RULE_05: While sharing is active the alternate ramp bit reads and acts as one.
// RULE_06: While sharing, bit 0 is push-pull for sync output, open-drain for input.
// RULE_07: While sharing, load-line resistance is forced to the fixed sharing code.
// RULE_08: Integrator gives group members consecutive addresses, reference lowest.
// RULE_09: Integrator sets ramp of 5 ms or more, reference delay 10 ms longer.
// RULE_10: Member-count strap decodes to group count three with sharing enabled.
// RULE_11: Position strap resistors decode to share positions zero, one and two.
// RULE_12: Sync pin driven as output when direction strap high, input when low.
// RULE_13: Soft-start strap gives 15 ms or 5 ms delay, both with 5 ms ramp.
// RULE_14: Lowest active share position is reference; next lowest takes over on dropout.
// RULE_15: Phase enabled while enable pin high, dropped while low; open is invalid.
// RULE_16: With sharing off, host-programmed ramp, sync-drive and load-line values stand.
module csc_top import csc_pkg::*; #(
  parameter int BLANK_W = 8 // Width of the blanking load value
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic cmd_valid, // Command transaction strobe
  input wire logic cmd_write, // 1 write word, 0 read word
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_wdata, // Write word
  output logic rsp_valid, // Answer strobe, one cycle
  output logic rsp_err, // Unsupported command or access
  output logic [15:0] rsp_data, // Read word
  input wire logic strap_valid, // Strap measurements ready
  input wire csc_strap_raw_t strap_raw, // Measured strap resistances
  input wire logic sync_direction_strap, // Sync direction strap level pin
  input wire logic phase_enable_pin, // Phase enable level pin
  input wire logic phase_enable_valid, // Low when phase enable pin is open
  input wire logic [7:0] peer_active, // Per-position peer alive flags
  input wire logic sync_clk_int, // Internal sync clock source
  input wire logic sw_edge, // Power switch transition pulse
  input wire logic meas_req, // Current measurement request pulse
  output logic meas_take, // Measurement granted pulse
  output logic sync_o, // Sync pin output value
  output logic sync_oe, // Sync pin output enable
  output logic share_en, // Current sharing active
  output logic [2:0] group_count, // Decoded number of members
  output logic [2:0] share_position, // Decoded share position
  output logic is_ref, // This controller is reference
  output logic phase_on, // Phase enabled
  output logic phase_bad, // Phase enable pin open
  output logic [7:0] ss_delay_ms, // Soft-start delay in ms
  output logic [7:0] ss_ramp_ms, // Soft-start ramp in ms
  output logic [1:0] sense_mode, // Active sensing mode
  output logic [15:0] cfg_eff, // Effective configuration word
  output logic [15:0] load_line_eff // Effective load-line resistance
);

  localparam int BLANK_STEP_CYC = (`CSC_BLANK_STEP_NS + `CSC_CLK_PERIOD_NS - 1)
                                  / `CSC_CLK_PERIOD_NS;

  csc_state_t st_r;
  csc_state_t st_nxt;
  csc_strap_t strap_dec;

  csc_strap_decode u_strap_decode (
    .raw(strap_raw),
    .dec(strap_dec)
  );

  // Applies the forced bits on top of the host value; sharing off leaves it untouched.
  function automatic logic [15:0] eff_cfg(input logic [15:0] cfg, input logic sh,
                                          input logic dir);
    logic [15:0] v;
    v = cfg;
    if (sh) begin
      v[`CSC_RAMP_BIT] = 1'b1; // RULE_05
      v[`CSC_SYNC_DRV_BIT] = dir; // RULE_06
    end
    return v; // RULE_16
  endfunction

  always_comb begin
    logic sh;
    logic [15:0] cfg_v;
    logic [15:0] ll_v;
    logic lower_alive;
    logic [BLANK_W-1:0] blank_len;
    st_nxt = st_r;
    sh = st_r.strap.share_en;
    lower_alive = 1'b0;
    blank_len = '0;
    cfg_v = eff_cfg(st_r.app_cfg, sh, st_r.dir_s2);
    ll_v = sh ? `CSC_LOAD_LINE_SHARE : st_r.load_line; // RULE_07 RULE_16

    // Straps are taken once after reset release; until then sharing stays off.
    if (!st_r.straps_taken && strap_valid) begin
      st_nxt.straps_taken = 1'b1;
      st_nxt.strap = strap_dec; // RULE_10 RULE_11 RULE_13
    end

    // Two-stage synchronisers for pin-level inputs.
    st_nxt.dir_s1 = sync_direction_strap;
    st_nxt.dir_s2 = st_r.dir_s1;
    st_nxt.phen_s1 = phase_enable_pin;
    st_nxt.phen_s2 = st_r.phen_s1;
    st_nxt.phok_s1 = phase_enable_valid;
    st_nxt.phok_s2 = st_r.phok_s1;
    st_nxt.peer_s1 = peer_active;
    st_nxt.peer_s2 = st_r.peer_s1;

    // An open pin never enables the phase.
    st_nxt.phase_on = st_r.phen_s2 && st_r.phok_s2; // RULE_15
    st_nxt.phase_bad = !st_r.phok_s2; // RULE_15

    // Reference is the alive controller with the lowest position.
    for (int i = 0; i < 8; i++) begin
      if (3'(i) < st_r.strap.position && st_r.peer_s2[i]) begin
        lower_alive = 1'b1; // RULE_14
      end
    end
    st_nxt.is_ref = sh && st_r.strap.pos_ok && st_r.phase_on && !lower_alive; // RULE_14

    // Sync pin: strap high drives it, bit 0 picks push-pull or open-drain drive.
    if (st_r.dir_s2) begin // RULE_12
      if (cfg_v[`CSC_SYNC_DRV_BIT]) begin // RULE_06
        st_nxt.sync_o = sync_clk_int;
        st_nxt.sync_oe = 1'b1;
      end else begin
        st_nxt.sync_o = 1'b0;
        st_nxt.sync_oe = !sync_clk_int;
      end
    end else begin
      st_nxt.sync_o = 1'b0;
      st_nxt.sync_oe = 1'b0; // RULE_12
    end

    // Blanking restarts on every switch edge, so a request in that cycle is refused.
    blank_len = BLANK_W'(st_r.app_cfg[`CSC_BLANK_HI:`CSC_BLANK_LO] * BLANK_STEP_CYC);
    if (sw_edge) begin
      st_nxt.blank_cnt = blank_len; // RULE_01
    end else if (st_r.blank_cnt != '0) begin
      st_nxt.blank_cnt = st_r.blank_cnt - 8'h01;
    end
    st_nxt.meas_take = meas_req && !sw_edge && (st_r.blank_cnt == '0); // RULE_01

    // Command port: answer one cycle after the strobe.
    st_nxt.rsp_valid = cmd_valid;
    st_nxt.rsp_err = 1'b0;
    st_nxt.rsp_data = 16'h0000;
    if (cmd_valid) begin
      case (cmd_code)
        `CSC_CMD_APP_CFG: begin
          if (cmd_write) begin
            st_nxt.app_cfg = cmd_wdata;
            // A reserved sense code is refused and the old mode kept.
            if (cmd_wdata[`CSC_SENSE_HI:`CSC_SENSE_LO] == `CSC_SENSE_RSVD) begin // RULE_03
              st_nxt.app_cfg[`CSC_SENSE_HI:`CSC_SENSE_LO] =
                st_r.app_cfg[`CSC_SENSE_HI:`CSC_SENSE_LO];
              st_nxt.rsp_err = 1'b1;
            end
          end else begin
            st_nxt.rsp_data = cfg_v;
          end
        end
        `CSC_CMD_LOAD_LINE: begin
          if (cmd_write) begin
            st_nxt.load_line = cmd_wdata; // RULE_16
          end else begin
            st_nxt.rsp_data = ll_v; // RULE_07
          end
        end
        `CSC_CMD_STATUS: begin
          if (cmd_write) begin
            st_nxt.rsp_err = 1'b1;
          end else begin
            st_nxt.rsp_data = {st_r.straps_taken, sh, st_r.is_ref, st_r.phase_on,
                               st_r.phase_bad, st_r.strap.pos_ok, st_r.strap.ss_ok,
                               st_r.dir_s2, 2'b00, st_r.strap.members,
                               st_r.strap.position};
          end
        end
        default: st_nxt.rsp_err = 1'b1;
      endcase
    end

    st_nxt.cfg_eff = cfg_v;
    st_nxt.load_line_eff = ll_v;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.app_cfg <= `CSC_APP_CFG_RST;
      st_r.load_line <= `CSC_LOAD_LINE_RST;
      st_r.cfg_eff <= `CSC_APP_CFG_RST;
      st_r.load_line_eff <= `CSC_LOAD_LINE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp_valid = st_r.rsp_valid;
  assign rsp_err = st_r.rsp_err;
  assign rsp_data = st_r.rsp_data;
  assign meas_take = st_r.meas_take;
  assign sync_o = st_r.sync_o;
  assign sync_oe = st_r.sync_oe;
  assign share_en = st_r.strap.share_en;
  assign group_count = st_r.strap.members;
  assign share_position = st_r.strap.position;
  assign is_ref = st_r.is_ref;
  assign phase_on = st_r.phase_on;
  assign phase_bad = st_r.phase_bad;
  assign ss_delay_ms = st_r.strap.ss_delay_ms;
  assign ss_ramp_ms = st_r.strap.ss_ramp_ms;
  assign sense_mode = st_r.app_cfg[`CSC_SENSE_HI:`CSC_SENSE_LO];
  assign cfg_eff = st_r.cfg_eff;
  assign load_line_eff = st_r.load_line_eff;

endmodule // csc_top

// file: bench/csc_monitor.sv
// Checker bound to the current sharing configuration top.
`timescale 1ns/1ps
`include "csc_regs.svh"
module csc_monitor (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic cmd_valid, // Command strobe
  input wire logic cmd_write, // Write flag
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [15:0] cmd_wdata, // Write word
  input wire logic rsp_valid, // Answer strobe
  input wire logic rsp_err, // Answer error
  input wire logic sync_direction_strap, // Sync direction
  input wire logic phase_enable_pin, // Phase enable
  input wire logic phase_enable_valid, // Pin not open
  input wire logic [7:0] peer_active, // Peer flags
  input wire logic sw_edge, // Switch edge
  input wire logic meas_req, // Measurement request
  input wire logic meas_take, // Measurement grant
  input wire logic sync_oe, // Sync drive enable
  input wire logic share_en, // Sharing active
  input wire logic [2:0] group_count, // Member count
  input wire logic [2:0] share_position, // Position
  input wire logic is_ref, // Reference role
  input wire logic phase_on, // Phase on
  input wire logic [15:0] cfg_eff, // Effective config
  input wire logic [15:0] load_line_eff // Effective load line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_blank_hold: assert property (sw_edge && cfg_eff[15:11] != 5'h00 |=> !meas_take ##1 !meas_take)
    else $error("measurement granted inside blanking");
  a_grant_cause: assert property (meas_take |-> $past(meas_req))
    else $error("grant without request");
  a_sense_refuse: assert property (cmd_valid && cmd_write && cmd_code == `CSC_CMD_APP_CFG
    && cmd_wdata[5:4] == 2'b11 |=> rsp_valid && rsp_err)
    else $error("reserved sense code accepted");
  a_ramp_forced: assert property (share_en && $past(share_en) |-> cfg_eff[2])
    else $error("ramp bit not forced");
  a_sync_drive: assert property ((share_en && $stable(sync_direction_strap))[*5]
    |-> cfg_eff[0] == sync_direction_strap)
    else $error("sync drive bit wrong");
  a_load_forced: assert property (share_en && $past(share_en)
    |-> load_line_eff == `CSC_LOAD_LINE_SHARE)
    else $error("load line not forced");
  a_count_three: assert property (share_en |-> group_count == `CSC_MEMBERS3)
    else $error("group count wrong");
  a_sync_input: assert property (!sync_direction_strap[*4] |-> !sync_oe)
    else $error("sync pin driven as input");
  a_ref_lowest: assert property ((peer_active[0] && share_position != 3'h0)[*5] |-> !is_ref)
    else $error("reference despite lower peer");
  a_phase_follow: assert property ($stable({phase_enable_pin, phase_enable_valid})[*4]
    |-> phase_on == (phase_enable_pin && phase_enable_valid))
    else $error("phase does not follow pin");
endmodule // csc_monitor

bind csc_top csc_monitor u_mon (.clk_sys, .rst_n, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
  .rsp_valid, .rsp_err, .sync_direction_strap, .phase_enable_pin, .phase_enable_valid,
  .peer_active, .sw_edge, .meas_req, .meas_take, .sync_oe, .share_en, .group_count,
  .share_position, .is_ref, .phase_on, .cfg_eff, .load_line_eff);

// file: bench/csc_peer_model.sv
// Peer controllers of a sharing group, seen as per-position alive flags.
`timescale 1ns/1ps
module csc_peer_model #(
  parameter logic [6:0] REF_ADDR = 7'h20, // Reference sits at the lowest group address
  parameter int REF_DLY_MS = 15, // Reference start delay, member delay plus ten
  parameter int MBR_DLY_MS = 5, // Member start delay, ramp five
  parameter int MEMBERS = 3 // Controllers in the group
) (
  input wire logic clk_sys, // Clock
  input wire logic [7:0] drop, // Positions dropped or faulted
  output logic [7:0] peer_active // Alive flag per position
);
  // Flags move just after an edge, like a real peer that drops out asynchronously.
  always @(posedge clk_sys) begin
    peer_active <= #1 ~drop & 8'((9'h001 << MEMBERS) - 9'h001);
  end
endmodule // csc_peer_model

// file: bench/tb_csc_top.sv
// Self-checking bench for the current sharing configuration block.
`timescale 1ns/1ps
`include "csc_regs.svh"
module tb_csc_top import csc_pkg::*;;
  logic clk_sys = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0, strap_valid = 0;
  logic sync_direction_strap = 0, phase_enable_pin = 1, phase_enable_valid = 1;
  logic sync_clk_int = 0, sw_edge = 0, meas_req = 0, rsp_valid, rsp_err, meas_take;
  logic sync_o, sync_oe, share_en, is_ref, phase_on, phase_bad;
  logic [7:0] cmd_code = 0, drop = 0, peer_active, ss_delay_ms, ss_ramp_ms;
  logic [15:0] cmd_wdata = 0, rsp_data, cfg_eff, load_line_eff;
  logic [2:0] group_count, share_position;
  logic [1:0] sense_mode;
  logic [17:0] e;
  logic [17:0] expq[$];
  logic [31:0] seed = 32'h42, r;
  logic [11:0] pos_tab[3] = '{`CSC_R_POS0, `CSC_R_POS1, `CSC_R_POS2};
  csc_strap_raw_t strap_raw = '0;
  int err_count = 0, checked = 0, k;
  csc_top DUT (.clk_sys, .rst_n, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid,
    .rsp_err, .rsp_data, .strap_valid, .strap_raw, .sync_direction_strap, .phase_enable_pin,
    .phase_enable_valid, .peer_active, .sync_clk_int, .sw_edge, .meas_req, .meas_take, .sync_o,
    .sync_oe, .share_en, .group_count, .share_position, .is_ref, .phase_on, .phase_bad,
    .ss_delay_ms, .ss_ramp_ms, .sense_mode, .cfg_eff, .load_line_eff);
  csc_peer_model PEER (.clk_sys, .drop, .peer_active);
  always #5 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  always @(negedge clk_sys) sync_clk_int <= ^xs();
  task automatic cmp(string what, logic [17:0] exp, logic [17:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Answers are matched in order; bit 17 of a note says whether the data matters.
  always @(negedge clk_sys) begin
    if (rsp_valid !== 1'b0) begin
      if (expq.size() == 0) begin
        err_count++;
        $display("BAD rsp_valid expected 0 seen 1");
      end else begin
        e = expq.pop_front();
        cmp("rsp_err", 18'(e[16]), 18'(rsp_err));
        if (e[17]) cmp("rsp_data", 18'(e[15:0]), 18'(rsp_data));
      end
    end
  end
  task automatic cmd(logic w, logic [7:0] c, logic [15:0] d, logic [17:0] x);
    cmd_valid = 1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    expq.push_back(x);
    @(negedge clk_sys);
  endtask
  task automatic idle(int n);
    cmd_valid = 0;
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic boot(logic [11:0] m, logic [11:0] p, logic [11:0] s, logic d);
    rst_n = 0;
    strap_valid = 0;
    strap_raw = '{m, p, s};
    sync_direction_strap = d;
    repeat (10) @(negedge clk_sys);
    rst_n = 1;
    strap_valid = 1;
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic tally_and_finish();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    boot(12'h000, `CSC_R_POS0, `CSC_R_SS_SHORT, 1'b1);
    cmp("share_en", 18'h00000, 18'(share_en));
    // Sharing off with bit 0 clear leaves the output pin open-drain.
    cmp("sync", 18'({1'b0, !sync_clk_int}), 18'({sync_o, sync_oe}));
    cmd(1'b1, `CSC_CMD_LOAD_LINE, 16'h1234, 18'h00000);
    cmd(1'b0, `CSC_CMD_LOAD_LINE, 16'h0000, 18'h21234);
    for (int i = 0; i < 3; i++) begin
      r = xs();
      r[5:4] = 2'(i);
      cmd(1'b1, `CSC_CMD_APP_CFG, r[15:0], 18'h00000);
      cmd(1'b0, `CSC_CMD_APP_CFG, 16'h0000, {2'b10, r[15:0]});
      idle(2);
      cmp("sense_mode", 18'(i), 18'(sense_mode));
    end
    cmd(1'b1, `CSC_CMD_APP_CFG, 16'h0030, 18'h10000);
    cmd(1'b0, `CSC_CMD_APP_CFG, 16'h0000, 18'h20020);
    cmd(1'b1, `CSC_CMD_STATUS, 16'hffff, 18'h10000);
    cmd(1'b1, 8'h00, 16'h0000, 18'h10000);
    cmd(1'b0, `CSC_CMD_LOAD_LINE, 16'h0000, 18'h21234);
    idle(2);
    $display("test host values done");
    for (int i = 0; i < 3; i++) begin
      boot(`CSC_R_MEMBERS3, pos_tab[i], i == 0 ? `CSC_R_SS_LONG : `CSC_R_SS_SHORT, i == 0);
      cmp("group", 18'(`CSC_MEMBERS3), 18'(group_count));
      cmp("share_en", 18'h00001, 18'(share_en));
      cmp("position", 18'(i), 18'(share_position));
      cmp("ss_delay", i == 0 ? 18'h0000f : 18'h00005, 18'(ss_delay_ms));
      cmp("ss_ramp", 18'h00005, 18'(ss_ramp_ms));
      cmp("sync_oe", 18'(i == 0), 18'(sync_oe));
      // The source still holds last cycle's value here, which is what the pin shows.
      cmp("sync_o", 18'(i == 0 && sync_clk_int), 18'(sync_o));
      cmp("is_ref", 18'(i == 0), 18'(is_ref));
      cmd(1'b1, `CSC_CMD_APP_CFG, 16'h0000, 18'h00000);
      cmd(1'b0, `CSC_CMD_APP_CFG, 16'h0000, {2'b10, 13'h0000, 2'b10, i == 0});
      cmd(1'b1, `CSC_CMD_LOAD_LINE, 16'h1234, 18'h00000);
      cmd(1'b0, `CSC_CMD_LOAD_LINE, 16'h0000, 18'h2ba80);
      cmd(1'b0, `CSC_CMD_STATUS, 16'h0000, {2'b10, 2'b11, i == 0, 1'b1, 1'b0, 2'b11, i == 0,
        2'b00, `CSC_MEMBERS3, 3'(i)});
      idle(2);
    end
    drop = 8'h01;
    idle(6);
    cmp("is_ref", 18'h00000, 18'(is_ref));
    drop = 8'h03;
    idle(6);
    cmp("is_ref", 18'h00001, 18'(is_ref));
    phase_enable_pin = 1'b0;
    idle(5);
    cmp("phase", 18'h00000, 18'({phase_on, is_ref, phase_bad}));
    phase_enable_pin = 1'b1;
    phase_enable_valid = 1'b0;
    idle(5);
    cmp("phase", 18'h00001, 18'({phase_on, is_ref, phase_bad}));
    phase_enable_valid = 1'b1;
    $display("test sharing straps done");
    for (int f = 0; f < 3; f++) begin
      r = xs();
      r[4:0] = f == 0 ? 5'h00 : f == 1 ? 5'h01 : r[4:0] | 5'h02;
      cmd(1'b1, `CSC_CMD_APP_CFG, {r[4:0], 11'h000}, 18'h00000);
      idle(3);
      sw_edge = 1'b1;
      @(negedge clk_sys);
      sw_edge = 1'b0;
      meas_req = 1'b1;
      k = 0;
      do begin
        @(negedge clk_sys);
        k++;
      end while (meas_take !== 1'b1 && k < 80);
      meas_req = 1'b0;
      // Counter loads two cycles per step, and the grant is one cycle after it empties.
      cmp("blank", 18'(2 * r[4:0] + 1), 18'(k));
    end
    idle(2);
    cmp("queue", 18'h00000, 18'(expq.size()));
    $display("test blanking done");
    tally_and_finish();
  end
endmodule // tb_csc_top
